// [usba_char_fifo.sv]
// Character queue used for both receive and transmit directions.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module usba_char_fifo
  import usba_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  localparam int AW   = $clog2(DEPTH),
  localparam int LW   = $clog2(DEPTH + 1)
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             pushValid,
  input  wire logic [WIDTH-1:0] pushData,
  output logic                  pushReady,
  output logic                  popValid,
  output logic [WIDTH-1:0]      popData,
  input  wire logic             popReady,
  output logic [LW-1:0]         level
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [LW-1:0]               level;
  } usba_fifo_s;

  usba_fifo_s fifo_reg;
  usba_fifo_s fifo_next;
  logic       doPush;
  logic       doPop;

  // A push while full is simply not taken, so the contents stay intact
  assign pushReady = fifo_reg.level != LW'(DEPTH); // R12
  assign popValid  = fifo_reg.level != '0;
  assign popData   = fifo_reg.mem[fifo_reg.rdPtr];
  assign level     = fifo_reg.level;
  assign doPush    = pushValid && pushReady;
  assign doPop     = popReady && popValid;

  always_comb begin
    fifo_next = fifo_reg;
    if (flush) begin
      fifo_next.wrPtr = '0;
      fifo_next.rdPtr = '0;
      fifo_next.level = '0;
    end else begin
      if (doPush) begin
        fifo_next.mem[fifo_reg.wrPtr] = pushData;
        fifo_next.wrPtr = (fifo_reg.wrPtr == AW'(DEPTH - 1)) ? '0
                        : fifo_reg.wrPtr + 1'b1;
      end
      if (doPop) begin
        fifo_next.rdPtr = (fifo_reg.rdPtr == AW'(DEPTH - 1)) ? '0
                        : fifo_reg.rdPtr + 1'b1;
      end
      fifo_next.level = fifo_reg.level + LW'(doPush) - LW'(doPop);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      fifo_reg <= '0;
    end else begin
      fifo_reg <= fifo_next;
    end
  end

endmodule

// [usba_line_model.sv]
// Remote transceiver on the far side of the serial and infrared lines.
// Assumes 8N1 frames, LSB first, BC clocks per bit, one shared clock.
`timescale 1ns/1ns
module usba_line_model #(
  parameter int BC = 4
) (
  input  wire logic sys_clk,
  input  wire logic serOut,
  output logic      serIn,
  output logic      sirIn
);
  logic [7:0] rxq[$];
  logic [7:0] sh;

  initial begin
    serIn = 1'b1;
    sirIn = 1'b0;
  end

  // The line not in use rests at its idle level
  task automatic send(input logic [7:0] c, input logic ir);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      if (ir) begin
        sirIn <= ~f[i];
      end else begin
        serIn <= f[i];
      end
      repeat (BC) @(posedge sys_clk);
    end
    repeat (2) @(posedge sys_clk);
  endtask

  // Mid-bit sampling; a glitch shorter than half a bit is dropped
  always begin
    @(negedge serOut);
    repeat (BC / 2) @(posedge sys_clk);
    if (serOut === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BC) @(posedge sys_clk);
        sh[i] = serOut;
      end
      repeat (BC) @(posedge sys_clk);
      rxq.push_back(sh);
    end
  end
endmodule

// [usba_map.svh]
// Address map, field positions, reset values and timing counts
// for the shadow character access block. Definitions only.
`ifndef USBA_MAP_SVH
`define USBA_MAP_SVH

// Sixteen aliased word slots; slot 13 and slot 14 sit at the printed places
`define USBA_SLOT_BASE     32'h5000_1130
`define USBA_SLOT13_ADDR   32'h5000_1164
`define USBA_SLOT14_ADDR   32'h5000_1168
`define USBA_SLOT_SPAN     32'h0000_0040
`define USBA_SLOT_RESET    32'h0000_0000

`define USBA_CTRL_ADDR     32'h5000_1180
`define USBA_LINE_ADDR     32'h5000_1184
`define USBA_IRQ_STAT_ADDR 32'h5000_1188
`define USBA_IRQ_MASK_ADDR 32'h5000_118C

// Queue control register fields
`define USBA_CTRL_QEN      0
`define USBA_CTRL_IRMODE   1
// Line state register fields
`define USBA_LINE_AVAIL    0
`define USBA_LINE_OVERRUN  1
`define USBA_LINE_HEMPTY   5
// Interrupt status and mask fields
`define USBA_IRQ_RX        0
`define USBA_IRQ_OVERRUN   1
`define USBA_IRQ_HEMPTY    2
`define USBA_IRQ_BITS      3

`define USBA_FIFO_DEPTH    16
`define USBA_BIT_CLKS      8
`define USBA_IR_PULSE_CLKS 2
`define USBA_FRAME_LAST    4'h9

`define USBA_RESP_OKAY     2'h0
`define USBA_RESP_DECERR   2'h3

`endif

// [usba_pkg.sv]
// Types shared by the shadow character access block.
// Assumes nothing of its surroundings.
package usba_pkg;

  typedef logic [7:0] usba_char_t;

  typedef enum logic {
    USBA_TX_IDLE,
    USBA_TX_SHIFT
  } usba_tx_e;

  typedef enum logic {
    USBA_RX_IDLE,
    USBA_RX_SHIFT
  } usba_rx_e;

endpackage

// [usba_shadow_access.sv]
// Shadow receive/transmit character access over AXI4-Lite, with a
// minimal serial and infrared line engine and optional character queues.
// Assumes one 125 MHz clock, synchronous inputs and a synchronous reset.
// Functional notes
// [R01] Sixteen word slots alias one character path
// [R02] Slot read returns received character in 7:0
// [R03] Software trusts data only while available flag set
// [R04] Queues off: new character overwrites, overrun flagged
// [R05] Queues on: slot read returns receive queue head
// [R06] Receive queue full: drop new character, overrun
// [R07] Written characters leave on serial or infrared line
// [R08] Software writes only while holding-empty flag set
// [R09] Queues off: a write clears holding-empty flag
// [R10] Queues off: later write replaces held character
// [R11] Queues on: accept writes up to queue depth
// [R12] Write into full transmit queue is discarded
// [R13] Every slot access moves exactly one character; a slot write with wStrb[0] clear moves none
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
`include "usba_map.svh"
module usba_shadow_access
  import usba_pkg::*;
#(
  parameter int DEPTH    = `USBA_FIFO_DEPTH,
  parameter int BIT_CLKS = `USBA_BIT_CLKS,
  localparam int LW      = $clog2(DEPTH + 1)
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        serIn,
  input  wire logic        sirIn,
  output logic             serOut,
  output logic             sirOutN,
  output logic             irq
);

  localparam logic [15:0] BIT_LAST  = 16'(BIT_CLKS - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CLKS / 2 - 1);
  localparam logic [15:0] IR_EDGE   = 16'(BIT_CLKS - `USBA_IR_PULSE_CLKS);

  typedef struct packed {
    usba_tx_e                  txState;
    logic [9:0]                txFrame;
    logic [3:0]                txBits;
    logic [15:0]               txCnt;
    usba_rx_e                  rxState;
    usba_char_t                rxShift;
    logic [3:0]                rxBits;
    logic [15:0]               rxCnt;
    usba_char_t                rxHold;
    logic                      rxHoldValid;
    usba_char_t                txHold;
    logic                      txHoldFull;
    logic                      queueEn;
    logic                      irMode;
    logic                      overrun;
    logic                      heLast;
    logic [`USBA_IRQ_BITS-1:0] irqStat;
    logic [`USBA_IRQ_BITS-1:0] irqMask;
    logic                      awHeld;
    logic [31:0]               awAddr;
    logic                      wHeld;
    logic [31:0]               wData;
    logic [3:0]                wStrb;
    logic                      awReady;
    logic                      wReady;
    logic                      bValid;
    logic [1:0]                bResp;
    logic                      arReady;
    logic                      rValid;
    logic [31:0]               rData;
    logic [1:0]                rResp;
    logic                      serOut;
    logic                      sirOutN;
    logic                      irq;
  } usba_state_s;

  usba_state_s st_reg;
  usba_state_s st_next;

  logic             rdTake;
  logic             rdSlot;
  logic             wrDo;
  logic             wrSlot;
  logic             rxDone;
  logic             rxLine;
  logic             heFlag;
  logic             charAvail;
  logic             flush;
  logic             rxPush;
  logic             rxPop;
  logic             txPush;
  logic             txPop;
  logic             rxqReady;
  logic             rxqValid;
  usba_char_t       rxqData;
  logic             txqReady;
  logic             txqValid;
  usba_char_t       txqData;
  logic [LW-1:0]    rxqLevel;
  logic [LW-1:0]    txqLevel;

  function automatic logic slotHit(input logic [31:0] addr);
    slotHit = (addr - `USBA_SLOT_BASE) < `USBA_SLOT_SPAN;
  endfunction

  assign rdTake = s_axi_arvalid && st_reg.arReady;
  assign rdSlot = rdTake && slotHit(s_axi_araddr); // R01
  assign wrDo   = st_reg.awHeld && st_reg.wHeld && !st_reg.bValid;
  assign wrSlot = wrDo && slotHit(st_reg.awAddr) && st_reg.wStrb[0]; // R01
  assign rxLine = st_reg.irMode ? !sirIn : serIn;
  assign rxDone = st_reg.rxState == USBA_RX_SHIFT && st_reg.rxCnt == '0
               && st_reg.rxBits == `USBA_FRAME_LAST;
  assign charAvail = st_reg.queueEn ? rxqValid : st_reg.rxHoldValid; // R03
  assign heFlag = st_reg.queueEn ? !txqValid : !st_reg.txHoldFull;
  // Switching queue mode drops queued characters, as a stale mix is useless
  assign flush  = wrDo && st_reg.awAddr == `USBA_CTRL_ADDR && st_reg.wStrb[0]
               && st_reg.wData[`USBA_CTRL_QEN] != st_reg.queueEn;
  assign rxPush = rxDone && st_reg.queueEn;
  assign rxPop  = rdSlot && st_reg.queueEn; // R13
  assign txPush = wrSlot && st_reg.queueEn; // R13 R11
  assign txPop  = st_reg.txState == USBA_TX_IDLE && st_reg.queueEn;

  usba_char_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rxQueue (
    .clk       (sys_clk),
    .rst       (sys_rst),
    .flush     (flush),
    .pushValid (rxPush),
    .pushData  (st_reg.rxShift),
    .pushReady (rxqReady),
    .popValid  (rxqValid),
    .popData   (rxqData),
    .popReady  (rxPop),
    .level     (rxqLevel)
  );

  usba_char_fifo #(.WIDTH(8), .DEPTH(DEPTH)) txQueue (
    .clk       (sys_clk),
    .rst       (sys_rst),
    .flush     (flush),
    .pushValid (txPush),
    .pushData  (st_reg.wData[7:0]),
    .pushReady (txqReady),
    .popValid  (txqValid),
    .popData   (txqData),
    .popReady  (txPop),
    .level     (txqLevel)
  );

  always_comb begin
    logic [`USBA_IRQ_BITS-1:0] ev;
    logic                      txAvail;
    ev = '0;
    txAvail = st_reg.queueEn ? txqValid : st_reg.txHoldFull;
    st_next = st_reg;

    // Transmit engine: start bit, eight data bits, stop bit
    unique case (st_reg.txState)
      USBA_TX_IDLE: begin
        if (txAvail) begin
          st_next.txFrame = {1'b1,
                             st_reg.queueEn ? txqData : st_reg.txHold,
                             1'b0};
          st_next.txBits  = '0;
          st_next.txCnt   = BIT_LAST;
          st_next.txState = USBA_TX_SHIFT;
          if (!st_reg.queueEn) begin
            st_next.txHoldFull = 1'b0;
          end
        end
      end
      USBA_TX_SHIFT: begin
        if (st_reg.txCnt != '0) begin
          st_next.txCnt = st_reg.txCnt - 16'h0001;
        end else if (st_reg.txBits == `USBA_FRAME_LAST) begin
          st_next.txState = USBA_TX_IDLE;
        end else begin
          st_next.txFrame = {1'b1, st_reg.txFrame[9:1]};
          st_next.txBits  = st_reg.txBits + 4'h1;
          st_next.txCnt   = BIT_LAST;
        end
      end
    endcase
    // Infrared zero bits are a short low pulse at the start of the bit
    st_next.serOut  = st_reg.irMode
                   || st_next.txState == USBA_TX_IDLE
                   || st_next.txFrame[0]; // R07
    st_next.sirOutN = !(st_reg.irMode && st_next.txState == USBA_TX_SHIFT
                     && !st_next.txFrame[0]
                     && st_next.txCnt >= IR_EDGE); // R07

    // Receive engine samples mid-bit; stop bit value is not checked
    unique case (st_reg.rxState)
      USBA_RX_IDLE: begin
        if (!rxLine) begin
          st_next.rxState = USBA_RX_SHIFT;
          st_next.rxBits  = '0;
          st_next.rxCnt   = HALF_LAST;
        end
      end
      USBA_RX_SHIFT: begin
        if (st_reg.rxCnt != '0) begin
          st_next.rxCnt = st_reg.rxCnt - 16'h0001;
        end else if (rxDone) begin
          st_next.rxState = USBA_RX_IDLE;
        end else if (st_reg.rxBits == '0 && rxLine) begin
          st_next.rxState = USBA_RX_IDLE;
        end else begin
          if (st_reg.rxBits != '0) begin
            st_next.rxShift = {rxLine, st_reg.rxShift[7:1]};
          end
          st_next.rxBits = st_reg.rxBits + 4'h1;
          st_next.rxCnt  = BIT_LAST;
        end
      end
    endcase

    // Read channel
    if (rdTake) begin
      st_next.arReady = 1'b0;
      st_next.rValid  = 1'b1;
      st_next.rResp   = `USBA_RESP_OKAY;
      st_next.rData   = '0;
      if (rdSlot) begin
        if (st_reg.queueEn) begin
          st_next.rData[7:0] = rxqData; // R05
        end else begin
          st_next.rData[7:0] = st_reg.rxHold; // R02
          st_next.rxHoldValid = 1'b0; // R13
        end
      end else if (s_axi_araddr == `USBA_CTRL_ADDR) begin
        st_next.rData[`USBA_CTRL_QEN]    = st_reg.queueEn;
        st_next.rData[`USBA_CTRL_IRMODE] = st_reg.irMode;
      end else if (s_axi_araddr == `USBA_LINE_ADDR) begin
        st_next.rData[`USBA_LINE_AVAIL]   = charAvail;
        st_next.rData[`USBA_LINE_OVERRUN] = st_reg.overrun;
        st_next.rData[`USBA_LINE_HEMPTY]  = heFlag;
        st_next.overrun = 1'b0;
      end else if (s_axi_araddr == `USBA_IRQ_STAT_ADDR) begin
        st_next.rData[`USBA_IRQ_BITS-1:0] = st_reg.irqStat;
        st_next.irqStat = '0;
      end else if (s_axi_araddr == `USBA_IRQ_MASK_ADDR) begin
        st_next.rData[`USBA_IRQ_BITS-1:0] = st_reg.irqMask;
      end else begin
        st_next.rResp = `USBA_RESP_DECERR;
      end
    end else if (st_reg.rValid && s_axi_rready) begin
      st_next.rValid  = 1'b0;
      st_next.arReady = 1'b1;
    end

    // Arrival handling comes after the read so a same-cycle event wins
    if (rxDone) begin
      if (st_reg.queueEn) begin
        if (rxqReady) begin
          ev[`USBA_IRQ_RX] = 1'b1;
        end else begin
          ev[`USBA_IRQ_OVERRUN] = 1'b1; // R06
        end
      end else begin
        ev[`USBA_IRQ_RX] = 1'b1;
        ev[`USBA_IRQ_OVERRUN] = st_reg.rxHoldValid && !rdSlot; // R04
        st_next.rxHold = st_reg.rxShift; // R04
        st_next.rxHoldValid = 1'b1;
      end
    end

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && st_reg.awReady) begin
      st_next.awHeld  = 1'b1;
      st_next.awAddr  = s_axi_awaddr;
      st_next.awReady = 1'b0;
    end
    if (s_axi_wvalid && st_reg.wReady) begin
      st_next.wHeld  = 1'b1;
      st_next.wData  = s_axi_wdata;
      st_next.wStrb  = s_axi_wstrb;
      st_next.wReady = 1'b0;
    end
    if (wrDo) begin
      st_next.awHeld = 1'b0;
      st_next.wHeld  = 1'b0;
      st_next.bValid = 1'b1;
      st_next.bResp  = `USBA_RESP_OKAY;
      if (slotHit(st_reg.awAddr)) begin
        if (st_reg.wStrb[0] && !st_reg.queueEn) begin
          st_next.txHold     = st_reg.wData[7:0]; // R10
          st_next.txHoldFull = 1'b1; // R09
        end
      end else if (st_reg.awAddr == `USBA_CTRL_ADDR) begin
        if (st_reg.wStrb[0]) begin
          st_next.queueEn = st_reg.wData[`USBA_CTRL_QEN];
          st_next.irMode  = st_reg.wData[`USBA_CTRL_IRMODE];
        end
      end else if (st_reg.awAddr == `USBA_IRQ_MASK_ADDR) begin
        if (st_reg.wStrb[0]) begin
          st_next.irqMask = st_reg.wData[`USBA_IRQ_BITS-1:0];
        end
      end else if (st_reg.awAddr != `USBA_LINE_ADDR
                && st_reg.awAddr != `USBA_IRQ_STAT_ADDR) begin
        st_next.bResp = `USBA_RESP_DECERR;
      end
    end else if (st_reg.bValid && s_axi_bready) begin
      st_next.bValid  = 1'b0;
      st_next.awReady = 1'b1;
      st_next.wReady  = 1'b1;
    end

    // Sticky status: events set over a read-clear in the same cycle
    ev[`USBA_IRQ_HEMPTY] = heFlag && !st_reg.heLast;
    st_next.heLast  = heFlag;
    st_next.overrun = st_next.overrun | ev[`USBA_IRQ_OVERRUN];
    st_next.irqStat = st_next.irqStat | ev;
    st_next.irq     = |(st_next.irqStat & st_next.irqMask);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg         <= '0;
      st_reg.heLast  <= 1'b1;
      st_reg.awReady <= 1'b1;
      st_reg.wReady  <= 1'b1;
      st_reg.arReady <= 1'b1;
      st_reg.serOut  <= 1'b1;
      st_reg.sirOutN <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = st_reg.awReady;
  assign s_axi_wready  = st_reg.wReady;
  assign s_axi_bvalid  = st_reg.bValid;
  assign s_axi_bresp   = st_reg.bResp;
  assign s_axi_arready = st_reg.arReady;
  assign s_axi_rvalid  = st_reg.rValid;
  assign s_axi_rdata   = st_reg.rData;
  assign s_axi_rresp   = st_reg.rResp;
  assign serOut        = st_reg.serOut;
  assign sirOutN       = st_reg.sirOutN;
  assign irq           = st_reg.irq;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_slot_head;
    rdSlot && st_reg.queueEn && rxqValid |=> s_axi_rvalid
      && s_axi_rdata == {24'h000000, $past(rxqData)};
  endproperty
  a_slot_head: assert property (p_slot_head) // R05
    else $error("slot read did not return queue head");

  property p_slot_hold;
    rdSlot && !st_reg.queueEn |=> s_axi_rdata[7:0] == $past(st_reg.rxHold)
      && s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_slot_hold: assert property (p_slot_hold) // R02
    else $error("slot read did not return held character");

  property p_overwrite;
    rxDone && !st_reg.queueEn && st_reg.rxHoldValid && !rdSlot
      |=> st_reg.overrun && st_reg.rxHold == $past(st_reg.rxShift);
  endproperty
  a_overwrite: assert property (p_overwrite) // R04
    else $error("overwrite without overrun");

  property p_full_drop;
    rxDone && st_reg.queueEn && !rxqReady && !rxPop && !flush
      |=> st_reg.overrun && rxqLevel == $past(rxqLevel);
  endproperty
  a_full_drop: assert property (p_full_drop) // R06
    else $error("full receive queue changed or no overrun");

  property p_start_bit;
    st_reg.txState == USBA_TX_IDLE && st_reg.queueEn && txqValid
      |=> $past(st_reg.irMode) ? (!sirOutN && serOut) : !serOut;
  endproperty
  a_start_bit: assert property (p_start_bit) // R07
    else $error("start bit not driven on line");

  property p_he_clear;
    wrSlot && !st_reg.queueEn && heFlag |=> !heFlag;
  endproperty
  a_he_clear: assert property (p_he_clear) // R09
    else $error("holding-empty flag stayed set after write");

  property p_replace;
    wrSlot && !st_reg.queueEn && st_reg.txState == USBA_TX_SHIFT
      |=> st_reg.txHold == $past(st_reg.wData[7:0]) && !heFlag;
  endproperty
  a_replace: assert property (p_replace) // R10
    else $error("held character not replaced");

  property p_accept;
    txPush && !txPop && txqLevel < LW'(DEPTH)
      |=> txqLevel == $past(txqLevel) + 1'b1;
  endproperty
  a_accept: assert property (p_accept) // R11
    else $error("write below depth not queued");

  property p_discard;
    txPush && !txqReady && !(txPop && txqValid)
      |=> txqLevel == LW'(DEPTH) && txqData == $past(txqData);
  endproperty
  a_discard: assert property (p_discard) // R12
    else $error("write into full queue altered it");

  property p_one_pop;
    rxPop && rxqValid && !(rxPush && rxqReady) && !flush
      |=> rxqLevel == $past(rxqLevel) - 1'b1;
  endproperty
  a_one_pop: assert property (p_one_pop) // R13
    else $error("slot read did not move one character");

  c_queue_fill: cover property (txPush && !txqReady);
  c_rx_overrun: cover property (rxDone && st_reg.rxHoldValid);
  c_ir_send: cover property (st_reg.irMode && !sirOutN);
  c_burst: cover property (rdSlot ##[1:4] rdSlot);

endmodule

// [usba_shadow_access_tb.sv]
// Bench for the shadow character path: AXI4-Lite master tasks and a
// line partner. Small queue depth and bit time keep the run short.
`timescale 1ns/1ns
`include "usba_map.svh"
module usba_shadow_access_tb;
  import usba_pkg::*;
  localparam int DEPTH = 4;
  localparam int BC    = 4;
  logic        sys_clk, sys_rst, irq;
  logic [31:0] awaddr, wdata, araddr, rdata, v;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic        serIn, sirIn, serOut, sirOutN;
  int          bad_count, num_checks, irLow, serLow, a, b;

  usba_shadow_access #(.DEPTH(DEPTH), .BIT_CLKS(BC)) DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serIn(serIn), .sirIn(sirIn), .serOut(serOut),
    .sirOutN(sirOutN), .irq(irq));
  usba_line_model #(.BC(BC)) lm (.sys_clk(sys_clk), .serOut(serOut),
    .serIn(serIn), .sirIn(sirIn));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (!sirOutN) irLow++;
    if (!serOut) serLow++;
  end

  task automatic summarize();
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      chk("wait", 32'h0, 32'h1);
      summarize();
    end
  endtask
  task automatic wr(input logic [31:0] ad, d, output logic [1:0] rs);
    int n;
    logic pa, pw;
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (pa && awready) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end while (!bvalid && n < 200);
    rs = bresp;
    bready <= 1'b0;
    tmo(n, 200);
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [31:0] ad, output logic [31:0] d,
                    output logic [1:0] rs);
    int n;
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
    tmo(n, 200);
    @(posedge sys_clk);
  endtask
  task automatic wq(input int k);
    int n;
    n = 0;
    while (lm.rxq.size() < k && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    tmo(n, 3000);
  endtask

  initial begin
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    {bad_count, num_checks, irLow, serLow} = '0;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    rd(`USBA_SLOT13_ADDR, v, r);
    chk("slot13", v, `USBA_SLOT_RESET);
    rd(`USBA_SLOT14_ADDR, v, r);
    chk("slot14", v, `USBA_SLOT_RESET);
    rd(`USBA_LINE_ADDR, v, r);
    chk("line", v, 32'h20);
    rd(32'h5000_1200, v, r);
    chk("rresp", r, `USBA_RESP_DECERR);
    chk("rdata", v, 32'h0);
    wr(32'h5000_1200, 32'h1, r);
    chk("bresp", r, `USBA_RESP_DECERR);
    // Queues off: second arrival overwrites the unread first
    wr(`USBA_IRQ_MASK_ADDR, 32'h2, r);
    lm.send(8'h3C, 1'b0);
    lm.send(8'hC3, 1'b0);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(`USBA_LINE_ADDR, v, r);
    chk("line", v, 32'h23);
    rd(`USBA_SLOT_BASE + 32'h3C, v, r);
    chk("slot15", v, 32'hC3);
    rd(`USBA_LINE_ADDR, v, r);
    chk("line", v, 32'h20);
    rd(`USBA_IRQ_STAT_ADDR, v, r);
    chk("stat", v & 32'h3, 32'h3);
    repeat (2) @(posedge sys_clk);
    chk("irq", {31'h0, irq}, 32'h0);
    // Queues on: one arrival beyond the depth is dropped
    wr(`USBA_CTRL_ADDR, 32'h1, r);
    for (int i = 0; i <= DEPTH; i++) lm.send(8'(8'h50 + i), 1'b0);
    rd(`USBA_LINE_ADDR, v, r);
    chk("line", v & 32'h3, 32'h3);
    for (int i = 0; i < DEPTH; i++) begin
      rd(`USBA_SLOT_BASE + 4 * i, v, r);
      chk("head", v, 32'h50 + i);
    end
    rd(`USBA_LINE_ADDR, v, r);
    chk("line", v & 32'h1, 32'h0);
    // Queues off: a write into a full holding register replaces it
    wr(`USBA_CTRL_ADDR, 32'h0, r);
    wr(`USBA_SLOT_BASE, 32'h11, r);
    wr(`USBA_SLOT_BASE + 32'h4, 32'h22, r);
    rd(`USBA_LINE_ADDR, v, r);
    chk("line", v & 32'h20, 32'h0);
    wr(`USBA_SLOT_BASE + 32'h8, 32'h33, r);
    wq(2);
    repeat (12 * BC) @(posedge sys_clk);
    chk("txn", lm.rxq.size(), 32'h2);
    chk("tx0", lm.rxq[0], 32'h11);
    chk("tx1", lm.rxq[1], 32'h33);
    rd(`USBA_IRQ_STAT_ADDR, v, r);
    chk("hestat", v & 32'h4, 32'h4);
    lm.rxq.delete();
    // Queues on: burst beyond the depth; the excess is lost
    wr(`USBA_CTRL_ADDR, 32'h1, r);
    for (int i = 0; i < DEPTH + 3; i++)
      wr(`USBA_SLOT_BASE + 4 * i, 32'h60 + i, r);
    wq(DEPTH);
    repeat (24 * BC) @(posedge sys_clk);
    a = lm.rxq.size();
    chk("txn", 32'(a >= DEPTH && a <= DEPTH + 1), 32'h1);
    for (int i = 0; i < a; i++)
      chk("txq", lm.rxq[i], 32'h60 + i);
    // Infrared: receive on sirIn, zero bits pulse sirOutN low
    wr(`USBA_CTRL_ADDR, 32'h3, r);
    lm.send(8'h96, 1'b1);
    rd(`USBA_LINE_ADDR, v, r);
    chk("line", v & 32'h1, 32'h1);
    rd(`USBA_SLOT_BASE + 32'h1C, v, r);
    chk("irrx", v, 32'h96);
    a = irLow;
    b = serLow;
    wr(`USBA_SLOT_BASE + 32'hC, 32'hA5, r);
    repeat (12 * BC) @(posedge sys_clk);
    chk("irlow", 32'(irLow - a), 5 * `USBA_IR_PULSE_CLKS);
    chk("serlow", 32'(serLow - b), 32'h0);
    summarize();
  end
endmodule
